// ---- pkg/vcd_defs.vh ----
// Purpose: shared constants of the video and cursor fetch address unit
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef VCD_DEFS_VH
`define VCD_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define VCD_OFS_CUR_CUR 12'h1C0
`define VCD_OFS_CUR_INIT 12'h1C4
`define VCD_OFS_LOW_CUR 12'h1C8
`define VCD_OFS_VID_CUR 12'h1D0
`define VCD_OFS_VID_END 12'h1D4
`define VCD_OFS_VID_START 12'h1D8
`define VCD_OFS_VID_INIT 12'h1DC
`define VCD_OFS_VID_CTL 12'h1E0

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define VCD_ADDR_MSB 28
`define VCD_ADDR_LSB 4
`define VCD_END_MSB 23
`define VCD_LAST_BIT 30
`define VCD_EQ_BIT 29
`define VCD_CTL_DUAL_BIT 7
`define VCD_CTL_ENA_BIT 5
`define VCD_CTL_FIXED 8'h50
`define VCD_CTL_FIXED_MASK 8'h5F

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define VCD_ADDR_RST 25'h0000000
`define VCD_END_RST 20'h00000
`define VCD_RESP_OKAY 2'h0
`define VCD_RESP_SLVERR 2'h2

`endif

// ---- rtl/vcd_fetch_ptr.v ----
// Purpose: one fetch pointer in qword units with reload, step and wrap
// Assumes: software write and step are one-cycle qualified inputs, reload may be held as a level
// Notes: software write wins over reload, reload wins over step
`timescale 1ns/1ps
module vcd_fetch_ptr #(
    parameter AW = 25,
    parameter EW = 20
) (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // software access
    input wire swWr,
    input wire [AW-1:0] swVal,
    // frame control
    input wire reload,
    input wire [AW-1:0] initVal,
    input wire step,
    input wire wrapEn,
    input wire [EW-1:0] endVal,
    input wire [AW-1:0] startVal,
    // pointer
    output reg [AW-1:0] cur_r,
    output wire atEnd
);
    wire [AW-1:0] cur_nxt;

    // only the low end bits are compared: the end field is narrower
    assign atEnd = (cur_r[EW-1:0] == endVal);
    assign cur_nxt = (wrapEn && atEnd) ? startVal : // [R19]
        cur_r + {{(AW-1){1'b0}}, 1'b1}; // [R2]

    always @(posedge core_clk) begin
        if (srst) begin
            cur_r <= {AW{1'b0}};
        end else if (swWr) begin
            cur_r <= swVal;
        end else if (reload) begin
            cur_r <= initVal; // [R6] [R14]
        end else if (step) begin
            cur_r <= cur_nxt;
        end
    end
endmodule

// ---- rtl/vcd_frame_sync.v ----
// Purpose: qualifies frame reload and per-channel fetch steps
// Assumes: channel 0 video, 1 lower panel, 2 cursor
// Notes: no step is taken while the retrace level is high
`timescale 1ns/1ps
module vcd_frame_sync #(
    parameter NCH = 3
) (
    // frame state
    input wire retrace,
    input wire dmaEna,
    input wire dualMode,
    // fetch completions
    input wire [NCH-1:0] fetchDone,
    // qualified controls
    output wire reload,
    output wire [NCH-1:0] step
);
    genvar i;

    assign reload = retrace; // [R1] [R5] [R6]

    generate
        for (i = 0; i < NCH; i = i + 1) begin : gStep
            if (i == 1) begin : gLow
                // the lower panel set stays idle outside dual mode
                assign step[i] = fetchDone[i] & dmaEna & dualMode &
                    ~retrace; // [R10]
            end else begin : gOther
                assign step[i] = fetchDone[i] & dmaEna & ~retrace; // [R2]
            end
        end
    endgenerate
endmodule

// ---- rtl/vcd_dma_addr.v ----
// Purpose: video and cursor fetch address unit with AXI4-Lite registers
// Assumes: fetch side gives one-cycle done pulses and a retrace level
// Notes: undefined read bits return zero
//
// Function
// [R1] retrace copies cursor initial into cursor current
// [R2] cursor pointer steps one qword per fetch
// [R3] fetch registers keep bits 28:4, low reads zero
// [R4] software loads cursor initial with buffer start
// [R5] lower panel current reloads from its initial
// [R6] retrace reloads every video current register
// [R7] end register keeps only bits 23:4
// [R8] software loads start with first frame qword
// [R9] addresses qword aligned, low four bits dropped
// [R10] single panel uses only the A set
// [R11] software loads initial A with top qword
// [R12] software sets last flag only when equal end
// [R13] initial A reads zero, last, equal, address
// [R14] each frame fetch starts at initial address
// [R15] control bit 7 selects dual panel, readable
// [R16] control bit 5 enables DMA, readable
// [R17] software keeps dual bit clear for CRT
// [R18] control bits 6, 4:0 fixed read 1,10000
// [R19] video fetch wraps from end to start
// [R20] software loads lower initial with panel top; here it comes from the lowerPanelInit input, with no register
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "vcd_defs.vh"
module vcd_dma_addr #(
    parameter AW = 25,
    parameter EW = 20
) (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // fetch side
    input wire retrace,
    input wire vidFetchDone,
    input wire lowFetchDone,
    input wire curFetchDone,
    input wire [AW-1:0] lowerPanelInit,
    output wire [AW-1:0] vidFetchQw,
    output wire [AW-1:0] lowFetchQw,
    output wire [AW-1:0] curFetchQw,
    output reg dmaEnable,
    output reg dualPanel
);
    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    reg [AW-1:0] curInit_r;
    reg [AW-1:0] frame_buffer_start_r;
    reg [AW-1:0] vidInit_r;
    reg [EW-1:0] frame_buffer_end_r;
    reg vidLast_r;
    reg [11:0] wrAddr_r;
    reg [31:0] wrData_r;
    reg [3:0] wrStrb_r;
    reg wrGo_r;
    reg [11:0] rdAddr_r;
    reg rdGo_r;

    wire [3*AW-1:0] ptrCur;
    wire [2:0] ptrAtEnd;
    wire [2:0] ptrWr;
    wire [2:0] ptrStep;
    wire [3*AW-1:0] ptrInit;
    wire [2:0] ptrWrap;
    wire reloadAll;
    wire [31:0] wrOld;
    wire [31:0] wrWord;
    wire [31:0] rdWord;
    wire wrHit;
    wire rdHit;
    wire [AW-1:0] wrQw;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    function hitOf;
        input [11:0] a;
        reg [11:0] w;
        begin
            w = {a[11:2], 2'b00};
            case (w)
                `VCD_OFS_CUR_CUR,
                `VCD_OFS_CUR_INIT,
                `VCD_OFS_LOW_CUR,
                `VCD_OFS_VID_CUR,
                `VCD_OFS_VID_END,
                `VCD_OFS_VID_START,
                `VCD_OFS_VID_INIT,
                `VCD_OFS_VID_CTL: hitOf = 1'b1;
                default: hitOf = 1'b0;
            endcase
        end
    endfunction

    function [31:0] qwWord;
        input [AW-1:0] q;
        begin
            qwWord = {3'b000, q, 4'h0}; // [R3]
        end
    endfunction

    function [31:0] readOf;
        input [11:0] a;
        reg [11:0] w;
        begin
            w = {a[11:2], 2'b00};
            case (w)
                `VCD_OFS_CUR_CUR: readOf = qwWord(ptrCur[3*AW-1:2*AW]);
                `VCD_OFS_CUR_INIT: readOf = qwWord(curInit_r);
                `VCD_OFS_LOW_CUR: readOf = qwWord(ptrCur[2*AW-1:AW]);
                `VCD_OFS_VID_CUR: readOf = qwWord(ptrCur[AW-1:0]);
                `VCD_OFS_VID_END:
                    readOf = {8'h00, frame_buffer_end_r, 4'h0}; // [R7]
                `VCD_OFS_VID_START: readOf = qwWord(frame_buffer_start_r);
                `VCD_OFS_VID_INIT:
                    readOf = {1'b0, vidLast_r, ptrAtEnd[0],
                        vidInit_r, 4'h0}; // [R13]
                `VCD_OFS_VID_CTL:
                    readOf = {24'h000000, dualPanel, 1'b0, dmaEnable,
                        5'h00} | {24'h000000, `VCD_CTL_FIXED}; // [R18]
                default: readOf = 32'h00000000;
            endcase
        end
    endfunction

    // partial strobes merge into the value the register shows now
    function [31:0] mergeOf;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] strb;
        integer k;
        begin
            mergeOf = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    mergeOf[8*k +: 8] = dat[8*k +: 8];
                end
            end
        end
    endfunction

    assign wrHit = hitOf(wrAddr_r);
    assign rdHit = hitOf(rdAddr_r);
    assign rdWord = readOf(rdAddr_r);
    assign wrOld = readOf(wrAddr_r);
    assign wrWord = mergeOf(wrOld, wrData_r, wrStrb_r);
    assign wrQw = wrWord[`VCD_ADDR_MSB:`VCD_ADDR_LSB]; // [R3] [R9]

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    // address and data are taken in either order; the store happens
    // in the cycle after both are held, the response in that same cycle
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VCD_RESP_OKAY;
            wrAddr_r <= 12'h000;
            wrData_r <= 32'h00000000;
            wrStrb_r <= 4'h0;
            wrGo_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wrData_r <= s_axi_wdata;
                wrStrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrGo_r) begin
                wrGo_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? `VCD_RESP_OKAY : `VCD_RESP_SLVERR;
            end else if (!s_axi_awready && !s_axi_wready &&
                    !s_axi_bvalid) begin
                wrGo_r <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `VCD_RESP_OKAY;
            rdAddr_r <= 12'h000;
            rdGo_r <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rdAddr_r <= s_axi_araddr;
                s_axi_arready <= 1'b0;
                rdGo_r <= 1'b1;
            end
            if (rdGo_r) begin
                rdGo_r <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdHit ? `VCD_RESP_OKAY : `VCD_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            curInit_r <= `VCD_ADDR_RST;
            frame_buffer_start_r <= `VCD_ADDR_RST;
            vidInit_r <= `VCD_ADDR_RST;
            frame_buffer_end_r <= `VCD_END_RST;
            vidLast_r <= 1'b0;
            dmaEnable <= 1'b0;
            dualPanel <= 1'b0;
        end else if (wrGo_r && wrHit) begin
            case ({wrAddr_r[11:2], 2'b00})
                `VCD_OFS_CUR_INIT: curInit_r <= wrQw; // [R3]
                `VCD_OFS_VID_START: frame_buffer_start_r <= wrQw; // [R3]
                `VCD_OFS_VID_END:
                    frame_buffer_end_r <= wrWord[`VCD_END_MSB:`VCD_ADDR_LSB]; // [R7]
                `VCD_OFS_VID_INIT: begin
                    vidInit_r <= wrQw;
                    vidLast_r <= wrWord[`VCD_LAST_BIT];
                end
                `VCD_OFS_VID_CTL: begin
                    dualPanel <= wrWord[`VCD_CTL_DUAL_BIT]; // [R15]
                    dmaEnable <= wrWord[`VCD_CTL_ENA_BIT]; // [R16]
                end
                default: begin
                    vidLast_r <= vidLast_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // fetch pointers
    // ------------------------------------------------------------------
    assign ptrWr[0] = wrGo_r && ({wrAddr_r[11:2], 2'b00} ==
        `VCD_OFS_VID_CUR);
    assign ptrWr[1] = wrGo_r && ({wrAddr_r[11:2], 2'b00} ==
        `VCD_OFS_LOW_CUR);
    assign ptrWr[2] = wrGo_r && ({wrAddr_r[11:2], 2'b00} ==
        `VCD_OFS_CUR_CUR);
    assign ptrInit = {curInit_r, lowerPanelInit, vidInit_r};
    // the cursor buffer is linear; both video sets wrap in the frame
    assign ptrWrap = 3'b011;

    vcd_frame_sync #(
        .NCH(3)
    ) uSync (
        .retrace(retrace),
        .dmaEna(dmaEnable),
        .dualMode(dualPanel),
        .fetchDone({curFetchDone, lowFetchDone, vidFetchDone}),
        .reload(reloadAll),
        .step(ptrStep)
    );

    genvar c;
    generate
        for (c = 0; c < 3; c = c + 1) begin : gPtr
            vcd_fetch_ptr #(
                .AW(AW),
                .EW(EW)
            ) uPtr (
                .core_clk(core_clk),
                .srst(srst),
                .swWr(ptrWr[c]),
                .swVal(wrQw),
                .reload(reloadAll),
                .initVal(ptrInit[c*AW +: AW]),
                .step(ptrStep[c]),
                .wrapEn(ptrWrap[c]),
                .endVal(frame_buffer_end_r),
                .startVal(frame_buffer_start_r),
                .cur_r(ptrCur[c*AW +: AW]),
                .atEnd(ptrAtEnd[c])
            );
        end
    endgenerate

    // pointer outputs are the pointer flip-flops themselves
    assign vidFetchQw = ptrCur[AW-1:0];
    assign lowFetchQw = ptrCur[2*AW-1:AW];
    assign curFetchQw = ptrCur[3*AW-1:2*AW];
endmodule

// ---- dv/vcd_dma_addr_chk.sv ----
// Purpose: port checks of the fetch address unit
// Assumes: bound to the top module, one clock
// Notes: pointer checks wait while a write is in flight
`timescale 1ns/1ps
module vcd_dma_addr_chk #(
    parameter AW = 25
) (
    input wire core_clk,
    input wire srst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire retrace,
    input wire curFetchDone,
    input wire [AW-1:0] lowerPanelInit,
    input wire [AW-1:0] vidFetchQw,
    input wire [AW-1:0] lowFetchQw,
    input wire [AW-1:0] curFetchQw,
    input wire dmaEnable,
    input wire dualPanel
);
    reg [11:0] rdAddr_r;
    wire quiet;
    // a write in flight may overwrite a pointer
    assign quiet = s_axi_awready && !retrace;
    always @(posedge core_clk) begin
        if (s_axi_arvalid && s_axi_arready)
            rdAddr_r <= s_axi_araddr;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence steadyRetrace;
        retrace && s_axi_awready ##1 retrace && s_axi_awready;
    endsequence
    wr_resp_time_a: assert property (
        wrTaken |=> !s_axi_bvalid ##[1:2] s_axi_bvalid)
        else $error("write response not on time");
    rd_resp_time_a: assert property (
        rdTaken |=> !s_axi_rvalid ##[1:2] s_axi_rvalid)
        else $error("read response not on time");
    low_bits_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[3:0] == 4'h0)
        else $error("low read bits not zero");
    ctl_fixed_a: assert property (
        s_axi_rvalid && rdAddr_r == 12'h1E0 |->
        s_axi_rdata[7:0] == {dualPanel, 1'b1, dmaEnable, 5'h10})
        else $error("control readback wrong");
    cur_step_a: assert property (
        quiet && dmaEnable && curFetchDone |=>
        curFetchQw == $past(curFetchQw) + 1'b1)
        else $error("cursor pointer did not step");
    cur_hold_a: assert property (
        quiet && !(dmaEnable && curFetchDone) |=> $stable(curFetchQw))
        else $error("cursor pointer moved");
    low_reload_a: assert property (
        retrace && s_axi_awready |=> lowFetchQw == $past(lowerPanelInit))
        else $error("lower pointer not reloaded");
    single_panel_a: assert property (
        quiet && !dualPanel |=> $stable(lowFetchQw))
        else $error("lower pointer moved in single mode");
    reload_steady_a: assert property (
        steadyRetrace |=> $stable(curFetchQw) && $stable(vidFetchQw))
        else $error("pointers drift during retrace");
endmodule
bind vcd_dma_addr vcd_dma_addr_chk #(.AW(AW)) u_chk (
    .core_clk(core_clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .retrace(retrace), .curFetchDone(curFetchDone),
    .lowerPanelInit(lowerPanelInit), .vidFetchQw(vidFetchQw),
    .lowFetchQw(lowFetchQw), .curFetchQw(curFetchQw),
    .dmaEnable(dmaEnable), .dualPanel(dualPanel)
);

// ---- dv/vcd_fetch_model.sv ----
// Purpose: fetch side stand-in, retrace then a run of fetches
// Assumes: go is a one-cycle pulse while idle
// Notes: gap 0 gives back-to-back done pulses, 3 the slowest
`timescale 1ns/1ps
module vcd_fetch_model (
    input wire core_clk,
    input wire srst,
    input wire go,
    input wire [7:0] nFetch,
    input wire [1:0] gap,
    output reg retrace,
    output reg fetchDone,
    output wire busy
);
    reg [7:0] left_r;
    reg [1:0] wait_r;
    reg [1:0] rt_r;
    assign busy = go || retrace || left_r != 8'h00;
    always @(posedge core_clk) begin
        fetchDone <= 1'b0;
        if (srst) begin
            retrace <= 1'b0;
            left_r <= 8'h00;
            rt_r <= 2'h0;
        end else if (go) begin
            retrace <= 1'b1;
            rt_r <= 2'h2;
            left_r <= nFetch;
            wait_r <= gap;
        end else if (retrace) begin
            rt_r <= rt_r - 2'h1;
            retrace <= rt_r != 2'h0;
        end else if (left_r != 8'h00) begin
            if (wait_r == 2'h0) begin
                fetchDone <= 1'b1;
                left_r <= left_r - 8'h01;
                wait_r <= gap;
            end else begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule

// ---- dv/vcd_dma_addr_tb.sv ----
// Purpose: self-checking bench of the fetch address unit
// Assumes: 200 MHz clock, reset held 3 cycles
// Notes: write strobes stay full, byte merge is not exercised
`timescale 1ns/1ps
`include "vcd_defs.vh"
module vcd_dma_addr_tb;
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg [11:0] awaddr = 12'h000;
    reg [11:0] araddr = 12'h000;
    reg [31:0] wdata = 32'h00000000;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    reg go = 1'b0;
    reg [7:0] nF = 8'h00;
    reg [1:0] gap = 2'h0;
    reg [24:0] lowInit = 25'h0000000;
    wire awready, wready, bvalid, arready, rvalid;
    wire retrace, done, busy, dmaEnable, dualPanel;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [24:0] vidQw, lowQw, curQw;
    integer n_errors = 0;
    integer checked = 0;
    integer k;
    reg [31:0] seed = 32'h00006293;
    reg [31:0] rd;
    reg [1:0] rsp;
    reg [24:0] st, en, ia, ci, v;
    reg [11:0] a;
    reg [7:0] ctl, n, m;
    always #2.5 core_clk = ~core_clk;
    vcd_dma_addr u_vcd_dma_addr (
        .core_clk(core_clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .retrace(retrace), .vidFetchDone(done), .lowFetchDone(done),
        .curFetchDone(done), .lowerPanelInit(lowInit),
        .vidFetchQw(vidQw), .lowFetchQw(lowQw), .curFetchQw(curQw),
        .dmaEnable(dmaEnable), .dualPanel(dualPanel));
    vcd_fetch_model u_vcd_fetch_model (
        .core_clk(core_clk), .srst(srst), .go(go), .nFetch(nF),
        .gap(gap), .retrace(retrace), .fetchDone(done), .busy(busy));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [31:0] fmask(input [11:0] ad, input [31:0] d);
        fmask = d & (ad == `VCD_OFS_VID_END ? 32'h00FFFFF0 : 32'h1FFFFFF0);
    endfunction
    // pointer after nf fetches, wrapping from end to start
    function [24:0] walk(input [24:0] p, input [7:0] nf);
        integer i;
        begin
            walk = p;
            for (i = 0; i < nf; i = i + 1)
                walk = (walk[19:0] == en[19:0]) ? st : walk + 25'h1;
        end
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("wrong value %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wrchk(input [11:0] ad, input [31:0] d, input [1:0] er);
        begin
            @(posedge core_clk);
            awaddr <= ad;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            // each channel drops its valid at the edge that takes it
            do begin
                @(posedge core_clk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
            end while (!bvalid);
            bready <= 1'b0;
            rsp = bresp;
            chk("bresp", er, rsp);
        end
    endtask
    task rdchk(input [11:0] ad, input [31:0] e, input [1:0] er);
        begin
            @(posedge core_clk);
            araddr <= ad;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge core_clk);
                if (arvalid && arready) arvalid <= 1'b0;
            end while (!rvalid);
            rready <= 1'b0;
            rd = rdata;
            rsp = rresp;
            chk("rdata", e, rd);
            chk("rresp", er, rsp);
        end
    endtask
    task frame(input [7:0] nf, input [1:0] g);
        integer t;
        begin
            @(posedge core_clk);
            go <= 1'b1;
            nF <= nf;
            gap <= g;
            @(posedge core_clk);
            go <= 1'b0;
            t = 0;
            while (busy && t < 2000) begin
                @(posedge core_clk);
                t = t + 1;
            end
            // a frame that never ends is a failure, not a silent skip
            if (t >= 2000) n_errors = n_errors + 1;
            repeat (2) @(posedge core_clk);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        rdchk(`VCD_OFS_VID_CTL, 32'h50, `VCD_RESP_OKAY);
        for (k = 0; k < 18; k++) begin
            seed = lfsr(seed);
            a = 12'h1C0 + 12'h4 * (k % 6 + (k % 6 > 2));
            wrchk(a, seed, `VCD_RESP_OKAY);
            rdchk(a, fmask(a, seed), `VCD_RESP_OKAY);
        end
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            ctl = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : seed[7:0];
            rd = {seed[31:8], ctl};
            wrchk(`VCD_OFS_VID_CTL, rd, `VCD_RESP_OKAY);
            rd = {24'h0, ctl[7], 1'b1, ctl[5], 5'h10};
            rdchk(`VCD_OFS_VID_CTL, rd, `VCD_RESP_OKAY);
            chk("dualPanel", ctl[7], dualPanel);
            chk("dmaEnable", ctl[5], dmaEnable);
        end
        for (k = 0; k < 2; k++) begin
            a = k ? 12'h1E4 : 12'h1CC;
            wrchk(a, seed, `VCD_RESP_SLVERR);
            rdchk(a, 32'h0, `VCD_RESP_SLVERR);
        end
        seed = lfsr(seed);
        en = {5'h00, seed[19:8], 8'h40};
        st = {5'h03, en[19:0] - 20'h00030};
        ci = {1'b0, seed[31:8]};
        lowInit <= {5'h03, en[19:0] - 20'h00003};
        wrchk(`VCD_OFS_VID_END, {3'h0, en, 4'h0}, `VCD_RESP_OKAY);
        wrchk(`VCD_OFS_VID_START, {3'h0, st, 4'h0}, `VCD_RESP_OKAY);
        wrchk(`VCD_OFS_CUR_INIT, {3'h0, ci, 4'h0}, `VCD_RESP_OKAY);
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            ia = {5'h03, en[19:0] - {16'h0000, seed[7:4]}};
            n = {4'h0, seed[3:0]} + 8'h03;
            ctl = (k == 3) ? 8'h00 : (k == 2) ? 8'hA0 : 8'h20;
            m = ctl[5] ? n : 8'h00;
            rd = {3'h0, ia, 4'h0};
            wrchk(`VCD_OFS_VID_INIT, rd, `VCD_RESP_OKAY);
            wrchk(`VCD_OFS_VID_CTL, {24'h0, ctl}, `VCD_RESP_OKAY);
            frame(n, k[1:0]);
            v = walk(ia, m);
            chk("vidQw", v, vidQw);
            chk("curQw", ci + {17'h0, m}, curQw);
            chk("lowQw", ctl[7] ? walk(lowInit, m) : lowInit,
                lowQw);
            rdchk(`VCD_OFS_VID_CUR, {3'h0, v, 4'h0}, `VCD_RESP_OKAY);
            rd = {2'b00, v[19:0] == en[19:0], ia, 4'h0};
            rdchk(`VCD_OFS_VID_INIT, rd, `VCD_RESP_OKAY);
        end
        rd = {3'b010, 5'h00, en[19:0], 4'h0};
        wrchk(`VCD_OFS_VID_INIT, rd, `VCD_RESP_OKAY);
        frame(8'h00, 2'h0);
        rd = {3'b011, 5'h00, en[19:0], 4'h0};
        rdchk(`VCD_OFS_VID_INIT, rd, `VCD_RESP_OKAY);
        report_and_stop;
    end
endmodule
